// File: rtl/iie_top.sv
// interrupt enable and acknowledge control with an axi4-lite register slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`include "iie_defs.svh"

// What this block does
// - transmit-empty request needs empty flag and enable
// - transmit-done request follows done flag when enabled
// - done request drops with flag or enable
// - receive-full request and sync overrun fault enabled
// - receive-full request drops with flag or enable
// - nack request on nack or lost arbitration
// - nack request drops with flags or enable
// - stop request only when stop enable set
// - check disabled ignores received acknowledge
// - checked acknowledge of one halts transfer
// - received acknowledge captured, software cannot write
// - receive mode drives stored acknowledge bit
module iie_top #(
	parameter int ADDR_W = 4 // byte address width of the slave
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire iie_pkg::iie_flags_t flags,
	input wire logic sync_format,
	input wire logic tx_mode,
	input wire logic ack_sample,
	input wire logic ack_sample_value,
	output iie_pkg::iie_req_t requests,
	output logic halt_transfer,
	output logic ack_drive_value
);

	// register state
	logic [7:0] en_r; // writable enable and ack bits
	logic ack_rcv_r; // received acknowledge, hardware only
	iie_pkg::iie_req_t req_r; // registered request lines
	iie_pkg::iie_req_t req_nxt; // next request levels
	logic halt_r; // halt continuous transfer
	logic ack_out_r; // acknowledge value for the bus

	// bus slave state
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	// handshake terms
	logic wr_go; // write address and data taken this edge
	logic rd_go; // read address taken this edge
	logic wr_hit; // write targets the enable register
	logic [7:0] en_view; // enable register as software reads it

	assign wr_go = awready_r && s_axi_awvalid && wready_r && s_axi_wvalid;
	assign rd_go = arready_r && s_axi_arvalid;
	// shift instead of a part-select, which would run backwards at the default width
	assign wr_hit = (s_axi_awaddr[3:2] == `IIE_IDX_ENABLE)
		&& ((s_axi_awaddr >> `IIE_ADDR_TOP) == '0);

	// read view puts the captured acknowledge into its slot
	always_comb begin
		en_view = en_r;
		en_view[`IIE_B_ACKR] = ack_rcv_r;
	end

	// request levels, each flag gated by its enable
	always_comb begin
		req_nxt.tx_empty_request = flags.tx_buffer_empty_flag && en_r[`IIE_B_TXE];
		// done flag is set by the unit at the ninth clock rise while empty
		req_nxt.tx_done_request = flags.tx_done_flag && en_r[`IIE_B_TX_DONE_FLAG];
		req_nxt.rx_full_request = flags.rx_buffer_full_flag && en_r[`IIE_B_RXF];
		// overrun fault counts only in clocked synchronous format
		req_nxt.rx_fault_request = sync_format && flags.rx_lost_word_flag
			&& (en_r[`IIE_B_RXF] || en_r[`IIE_B_NAK]);
		req_nxt.nack_request = en_r[`IIE_B_NAK]
			&& (flags.nack_seen_flag || flags.arbitration_lost_flag);
		req_nxt.stop_request = flags.stop_seen_flag && en_r[`IIE_B_STP];
	end

	// request registers, updated every clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_r <= '0;
		end else begin
			req_r <= req_nxt;
		end
	end

	// enable register, written by software on the low byte lane
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_r <= `IIE_EN_RST;
		end else if (wr_go && wr_hit && s_axi_wstrb[0]) begin
			// received acknowledge slot is not writable
			en_r <= s_axi_wdata[7:0] & `IIE_WR_MASK;
		end
	end

	// received acknowledge, captured at the slot in transmit mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_rcv_r <= 1'b0;
		end else if (ack_sample && tx_mode) begin
			ack_rcv_r <= ack_sample_value;
		end
	end

	// halt when checking is on and the partner answered one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_r <= 1'b0;
		end else begin
			// check off means the acknowledge never halts
			halt_r <= en_r[`IIE_B_ACK_CHECK_ENABLE] && ack_rcv_r;
		end
	end

	// acknowledge to send, presented only in receive mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_out_r <= 1'b0;
		end else begin
			ack_out_r <= !tx_mode && en_r[`IIE_B_ACKT];
		end
	end

	// write address and data ready, offered together one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
		end else begin
			awready_r <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
			wready_r <= s_axi_awvalid && s_axi_wvalid && !wready_r && !bvalid_r;
		end
	end

	// write response, slverr for unmapped or read-only words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `IIE_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? `IIE_RESP_OKAY : `IIE_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// read address ready, one cycle per request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
		end else begin
			arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
		end
	end

	// read data and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r <= `IIE_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			if ((s_axi_araddr >> `IIE_ADDR_TOP) != '0) begin
				// unmapped word reads zero with an error
				rresp_r <= `IIE_RESP_SLVERR;
				rdata_r <= 32'h0000_0000;
			end else if (s_axi_araddr[3:2] == `IIE_IDX_ENABLE) begin
				rresp_r <= `IIE_RESP_OKAY;
				rdata_r <= {24'h00_0000, en_view};
			end else if (s_axi_araddr[3:2] == `IIE_IDX_REQUEST) begin
				// live request lines for polling software
				rresp_r <= `IIE_RESP_OKAY;
				rdata_r <= {26'h000_0000, req_r};
			end else begin
				rresp_r <= `IIE_RESP_SLVERR;
				rdata_r <= 32'h0000_0000;
			end
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign requests = req_r;
	assign halt_transfer = halt_r;
	assign ack_drive_value = ack_out_r;

	// checks on the block's own behaviour
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// helper copies of single enable bits
	logic en_txe;
	logic en_tx_done_flag;
	logic en_rxf;
	logic en_nak;
	logic en_stp;
	logic en_ack_check_enable;
	assign en_txe = en_r[`IIE_B_TXE];
	assign en_tx_done_flag = en_r[`IIE_B_TX_DONE_FLAG];
	assign en_rxf = en_r[`IIE_B_RXF];
	assign en_nak = en_r[`IIE_B_NAK];
	assign en_stp = en_r[`IIE_B_STP];
	assign en_ack_check_enable = en_r[`IIE_B_ACK_CHECK_ENABLE];

	a_txe_request: assert property (
		req_r.tx_empty_request == ($past(en_txe) && $past(flags.tx_buffer_empty_flag)))
		else $error("tx empty request does not match flag and enable");

	a_tx_done_flag_rise: assert property (
		$rose(req_r.tx_done_request) |-> $past(en_tx_done_flag) && $past(flags.tx_done_flag))
		else $error("tx done request rose without flag and enable");

	a_tx_done_flag_cancel: assert property (
		(!en_tx_done_flag || !flags.tx_done_flag) |=> !req_r.tx_done_request)
		else $error("tx done request not withdrawn");

	a_rxf_request: assert property (
		(en_rxf && flags.rx_buffer_full_flag) |=> req_r.rx_full_request)
		else $error("rx full request missing");

	a_rxf_cancel: assert property (
		(!en_rxf || !flags.rx_buffer_full_flag) |=> !req_r.rx_full_request)
		else $error("rx full request not withdrawn");

	a_nak_request: assert property (
		en_nak && (flags.nack_seen_flag || flags.arbitration_lost_flag)
		|=> req_r.nack_request)
		else $error("nack request missing");

	a_nak_cancel: assert property (
		!en_nak |=> !req_r.nack_request && !(req_r.rx_fault_request && !$past(en_rxf)))
		else $error("nack or fault request not withdrawn");

	a_stp_gate: assert property (
		req_r.stop_request |-> $past(en_stp) && $past(flags.stop_seen_flag))
		else $error("stop request passed while blocked");

	a_ack_ignore: assert property (
		!en_ack_check_enable |=> !halt_r)
		else $error("halt raised with acknowledge check off");

	a_ack_halt: assert property (
		en_ack_check_enable && ack_rcv_r |=> halt_r)
		else $error("halt missing after checked acknowledge of one");

	a_ackr_capture: assert property (
		ack_sample && tx_mode |=> ack_rcv_r == $past(ack_sample_value))
		else $error("received acknowledge not captured");

	a_ackr_hold: assert property (
		!(ack_sample && tx_mode) |=> $stable(ack_rcv_r))
		else $error("received acknowledge changed without sample");

	a_ack_drive: assert property (
		!tx_mode |=> ack_out_r == $past(en_r[`IIE_B_ACKT]))
		else $error("acknowledge drive does not follow stored bit");

	a_reset_clear: assert property (
		!$past(aresetn) |-> en_r == `IIE_EN_RST && req_r == '0)
		else $error("enables not cleared by reset");

	a_fault_level: assert property (
		req_r.rx_fault_request == $past(sync_format && flags.rx_lost_word_flag
			&& (en_rxf || en_nak)))
		else $error("fault request does not follow flag and enables");

	a_bus_answer: assert property (
		wr_go |=> bvalid_r)
		else $error("write taken without response");

	// main scenarios
	c_txe_request: cover property (req_r.tx_empty_request);
	c_tx_done_flag_request: cover property ($rose(req_r.tx_done_request));
	c_fault_request: cover property (req_r.rx_fault_request);
	c_halt: cover property ($rose(halt_r));

endmodule : iie_top

// File: shared/iie_defs.svh
// register offsets, field positions, reset values and bus codes of the enable block
`ifndef IIE_DEFS_SVH
`define IIE_DEFS_SVH

// word index of each register (byte address bits [3:2])
`define IIE_IDX_ENABLE 2'h0
`define IIE_IDX_REQUEST 2'h1
// first byte address bit that must be zero for a mapped word
`define IIE_ADDR_TOP 4

// field positions inside irq_enable_register
`define IIE_B_TXE 7
`define IIE_B_TX_DONE_FLAG 6
`define IIE_B_RXF 5
`define IIE_B_NAK 4
`define IIE_B_STP 3
`define IIE_B_ACK_CHECK_ENABLE 2
`define IIE_B_ACKR 1
`define IIE_B_ACKT 0

// reset value and bits that software may change
`define IIE_EN_RST 8'h00
`define IIE_WR_MASK 8'hFD

// axi response codes
`define IIE_RESP_OKAY 2'h0
`define IIE_RESP_SLVERR 2'h2

`endif

// File: shared/iie_pkg.sv
// types shared by the interrupt enable block and its neighbours
package iie_pkg;

	// status flags arriving from the rest of the serial unit
	typedef struct packed {
		logic tx_buffer_empty_flag;
		logic tx_done_flag;
		logic rx_buffer_full_flag;
		logic nack_seen_flag;
		logic arbitration_lost_flag;
		logic rx_lost_word_flag;
		logic stop_seen_flag;
	} iie_flags_t;

	// request lines towards the interrupt controller
	typedef struct packed {
		logic tx_empty_request;
		logic tx_done_request;
		logic rx_full_request;
		logic rx_fault_request;
		logic nack_request;
		logic stop_request;
	} iie_req_t;

endpackage : iie_pkg

// File: testbench/iie_irq_sink.sv
// interrupt controller model that latches every request line it has seen
`timescale 1ns/1ns
module iie_irq_sink (
	input wire logic aclk,
	input wire logic aresetn,
	input wire iie_pkg::iie_req_t requests,
	output logic [5:0] seen_r
);
	// sticky record of raised request levels, cleared by reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen_r <= 6'h00;
		end else begin
			seen_r <= seen_r | requests;
		end
	end
endmodule : iie_irq_sink

// File: testbench/tb_top.sv
// self-checking bench for the interrupt enable block over axi4-lite
`timescale 1ns/1ns
`include "iie_defs.svh"
module tb_top;
	logic aclk, aresetn; // clock and active-low reset
	logic [3:0] awaddr, araddr; // bus addresses
	logic awvalid, wvalid, bready, arvalid, rready; // master handshakes
	logic awready, wready, bvalid, arready, rvalid; // slave handshakes
	logic [31:0] wdata, rdata; // bus data
	logic [1:0] bresp, rresp; // response codes
	iie_pkg::iie_flags_t flags; // status flags into the block
	logic sync_format, tx_mode, ack_sample, ack_sample_value; // unit controls
	iie_pkg::iie_req_t requests; // request lines out
	logic halt_transfer, ack_drive_value; // acknowledge outputs
	logic [5:0] seen; // requests caught by the controller model
	int fails = 0; // mismatch count
	int check_count = 0; // comparison count
	logic [7:0] ens [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'hF8, 8'h00}; // enable table
	logic [6:0] pat; // flag pattern under test
	logic [5:0] exp_req; // expected request levels
	logic [3:0] wstrb; // write byte strobes
	iie_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .flags(flags), .sync_format(sync_format),
		.tx_mode(tx_mode), .ack_sample(ack_sample), .ack_sample_value(ack_sample_value),
		.requests(requests), .halt_transfer(halt_transfer),
		.ack_drive_value(ack_drive_value));
	iie_irq_sink i_sink (.aclk(aclk), .aresetn(aresetn), .requests(requests), .seen_r(seen));
	// 100 ns clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// compare one word, reported and counted
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// expected request levels from enables, flags and format
	function automatic logic [5:0] ex(input logic [7:0] e, input logic [6:0] f, input logic s);
		ex = {f[6] & e[7], f[5] & e[6], f[4] & e[5], s & f[1] & (e[5] | e[4]),
			e[4] & (f[3] | f[2]), f[0] & e[3]};
	endfunction : ex
	// axi write: address and data together, bready held until the answer
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		// each channel released at the edge where its own ready is seen
		do begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done));
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	// axi read with expected data and response
	task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd
	// counts and verdict, the single end of the run
	task test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	// watchdog well beyond the expected run length
	initial begin
		#2000000;
		fails++;
		test_done;
	end
	// main sequence
	initial begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		{sync_format, tx_mode, ack_sample, ack_sample_value} = 4'h0;
		flags = 7'h00;
		wstrb = 4'h1;
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'h0, 32'h0, `IIE_RESP_OKAY);
		rd(4'h4, 32'h0, `IIE_RESP_OKAY);
		// every enable against every single flag and all flags together
		for (int i = 0; i < 7; i++) begin
			wr(4'h0, {24'h0, ens[i]}, `IIE_RESP_OKAY);
			for (int j = 0; j < 8; j++) begin
				pat = (j == 7) ? 7'h7F : (7'h01 << j);
				exp_req = ex(ens[i], pat, i[0] ^ j[0]);
				flags <= pat;
				sync_format <= i[0] ^ j[0];
				repeat (3) @(posedge aclk);
				chk({30'h0, requests[5:4]}, {30'h0, exp_req[5:4]});
				chk({30'h0, requests[3:2]}, {30'h0, exp_req[3:2]});
				chk({30'h0, requests[1:0]}, {30'h0, exp_req[1:0]});
			end
		end
		wr(4'h0, 32'h0000_00F8, `IIE_RESP_OKAY);
		rd(4'h4, {26'h0, ex(8'hF8, pat, sync_format)}, `IIE_RESP_OKAY);
		wr(4'h4, 32'h0, `IIE_RESP_SLVERR);
		rd(4'h8, 32'h0, `IIE_RESP_SLVERR);
		chk({26'h0, seen}, 32'h0000_003F);
		// acknowledge: drive value in receive mode, capture and halt in transmit mode
		wr(4'h0, 32'h0000_0005, `IIE_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk({31'h0, ack_drive_value}, 32'h1);
		tx_mode <= 1'b1;
		ack_sample <= 1'b1;
		ack_sample_value <= 1'b1;
		@(posedge aclk);
		ack_sample <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({30'h0, halt_transfer, ack_drive_value}, 32'h2);
		rd(4'h0, 32'h0000_0007, `IIE_RESP_OKAY);
		wr(4'h0, 32'h0000_0000, `IIE_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk({31'h0, halt_transfer}, 32'h0);
		rd(4'h0, 32'h0000_0002, `IIE_RESP_OKAY);
		// receive-mode sample and a write with no strobe leave the register alone
		tx_mode <= 1'b0;
		ack_sample <= 1'b1;
		ack_sample_value <= 1'b0;
		wstrb <= 4'h0;
		wr(4'h0, 32'h0000_00FF, `IIE_RESP_OKAY);
		ack_sample <= 1'b0;
		wstrb <= 4'h1;
		rd(4'h0, 32'h0000_0002, `IIE_RESP_OKAY);
		// reset in mid-run with enables set clears enables and outputs
		wr(4'h0, 32'h0000_00FD, `IIE_RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'h0, 32'h0, `IIE_RESP_OKAY);
		rd(4'h4, 32'h0, `IIE_RESP_OKAY);
		chk({30'h0, halt_transfer, ack_drive_value}, 32'h0);
		test_done;
	end
endmodule : tb_top
